/* tacp_pkg.sv */
// Constants and types for the address-with-context packet framer
// What this block does
// - A packet is a header byte, the address bytes, one context byte, an optional guest tag byte, then optional process tag bytes.
// - The address field names the next instruction the traced core executes.
// - Headers 0x82 (wide) and 0x83 (compact) carry four address bytes that replace only the low 32 history bits.
// - Headers 0x85 (wide) and 0x86 (compact) carry eight address bytes that replace the whole newest address.
// - In the wide set address bits 1:0 are zero and byte 0 holds bits 8:2 with its top bit zero.
// - In the compact set address bit 0 is zero and byte 0 holds bits 7:1 with its top bit zero.
// - Upper bits 63:32 that a four-byte packet leaves out come unchanged from the newest history entry; the low alignment bits are zero.
// - The two-bit privilege tier field codes levels zero to three directly.
// - The width state flag is 0 for 32-bit state and 1 for 64-bit state.
// - The secure world flag is 0 in Secure state and 1 in Non-secure state.
// - When the guest tag flag is set the guest tag byte follows the context byte, else it is left out.
// - When the process tag flag is set four process tag bytes follow, least significant first, else they are left out.
// - The guest tag byte holds the traced core's current virtual machine identifier.
// - The process tag bytes hold the traced core's current context identifier.
// - After the address is formed the three-entry history shifts by one and the newest entry takes the new address and set code.
package tacp_pkg;
    localparam logic [7:0] HDR_WIDE32    = 8'h82;
    localparam logic [7:0] HDR_COMPACT32 = 8'h83;
    localparam logic [7:0] HDR_WIDE64    = 8'h85;
    localparam logic [7:0] HDR_COMPACT64 = 8'h86;
    localparam logic [1:0] SET_WIDE      = 2'h0;
    localparam logic [1:0] SET_COMPACT   = 2'h1;
    localparam int         HIST_DEPTH    = 3;
    localparam logic [3:0] ADDR_BYTES32  = 4'h4;
    localparam logic [3:0] ADDR_BYTES64  = 4'h8;
    localparam logic [3:0] PTAG_BYTES    = 4'h4;
    // Context byte field positions
    localparam int CTX_PTAG_BIT  = 7;
    localparam int CTX_GTAG_BIT  = 6;
    localparam int CTX_NS_BIT    = 5;
    localparam int CTX_SF_BIT    = 4;
    localparam int CTX_TIER_LSB  = 0;

    typedef struct packed {
        logic [63:0] addr;
        logic [1:0]  isa;
    } tacp_hist_t;

    typedef enum logic [2:0] {S_IDLE, S_HDR, S_ADDR, S_CTX, S_GTAG, S_PTAG} tacp_state_t;
endpackage

/* tacp_hist_if.sv */
// Carrier for address history update and contents
interface tacp_hist_if;
    import tacp_pkg::*;
    logic        push;
    tacp_hist_t  newEntry;
    tacp_hist_t  entries [HIST_DEPTH];
    modport framer (output push, output newEntry, input entries);
    modport store  (input push, input newEntry, output entries);
endinterface

/* tacp_history.sv */
// Three-entry address history shift register
module tacp_history (
    input  wire logic   core_clk,
    input  wire logic   rst,
    tacp_hist_if.store  hist
);
    import tacp_pkg::*;
    tacp_hist_t regs [HIST_DEPTH];

    // Shift on push, newest written at index 0
    generate
        for (genvar i = 0; i < HIST_DEPTH; i++) begin : g_ent
            if (i == 0) begin : g_head
                always_ff @(posedge core_clk or posedge rst) begin
                    if (rst) begin
                        regs[i] <= '0;
                    end else if (hist.push) begin
                        regs[i] <= hist.newEntry;
                    end
                end
            end else begin : g_tail
                always_ff @(posedge core_clk or posedge rst) begin
                    if (rst) begin
                        regs[i] <= '0;
                    end else if (hist.push) begin
                        regs[i] <= regs[i-1];
                    end
                end
            end
            assign hist.entries[i] = regs[i];
        end
    endgenerate
endmodule

/* tacp_framer.sv */
// Address-with-context packet framer on the trace unit side
module tacp_framer (
    input  wire logic              core_clk,
    input  wire logic              rst,
    input  wire logic              pktReq,
    output logic                   pktAck,
    input  wire logic              wideAddr,
    input  wire logic              compactSet,
    input  wire logic [63:0]       nextAddr,
    input  wire logic [1:0]        privilegeTier,
    input  wire logic              widthStateFlag,
    input  wire logic              secureWorldFlag,
    input  wire logic              guestTagEn,
    input  wire logic [7:0]        guestTag,
    input  wire logic              processTagEn,
    input  wire logic [31:0]       processTag,
    output logic                   byteValid,
    output logic [7:0]             byteData,
    output logic                   byteLast,
    output logic [63:0]            newestAddr,
    output logic [1:0]             newestSet
);
    import tacp_pkg::*;

    tacp_hist_if hist ();
    tacp_history u_hist (
        .core_clk (core_clk),
        .rst      (rst),
        .hist     (hist)
    );

    tacp_state_t state;
    logic [63:0] addrReg;
    logic [3:0]  addrCnt;
    logic [3:0]  addrLen;
    logic [3:0]  ptagCnt;
    logic [1:0]  setReg;
    logic        longReg;
    logic [7:0]  ctxReg;
    logic [7:0]  gtagReg;
    logic [31:0] ptagReg;
    logic [63:0] next_addr;
    logic [1:0]  next_set;
    logic [7:0]  next_ctx;
    logic [7:0]  addrByte0;
    logic [7:0]  addrByte1;

    // Formed address: short packet keeps upper history bits
    always_comb begin
        next_set = compactSet ? SET_COMPACT : SET_WIDE;
        if (wideAddr) begin
            next_addr = nextAddr;
        end else begin
            next_addr = {hist.entries[0].addr[63:32], nextAddr[31:0]};
        end
        if (compactSet) begin
            next_addr[0] = 1'b0;
        end else begin
            next_addr[1:0] = 2'h0;
        end
        next_ctx = '0;
        next_ctx[CTX_PTAG_BIT] = processTagEn;
        next_ctx[CTX_GTAG_BIT] = guestTagEn;
        next_ctx[CTX_NS_BIT] = secureWorldFlag;
        next_ctx[CTX_SF_BIT] = widthStateFlag;
        next_ctx[CTX_TIER_LSB +: 2] = privilegeTier;
    end

    // First two address bytes depend on set: wide set leaves a zero top bit in both
    always_comb begin
        if (setReg == SET_COMPACT) begin
            addrByte0 = {1'b0, addrReg[7:1]};
            addrByte1 = addrReg[15:8];
        end else begin
            addrByte0 = {1'b0, addrReg[8:2]};
            addrByte1 = {1'b0, addrReg[15:9]};
        end
    end

    // Packet sequencer
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            state   <= S_IDLE;
            addrReg <= '0;
            addrCnt <= '0;
            addrLen <= '0;
            ptagCnt <= '0;
            setReg  <= SET_WIDE;
            longReg <= 1'b0;
            ctxReg  <= '0;
            gtagReg <= '0;
            ptagReg <= '0;
        end else begin
            unique case (state)
                S_IDLE: begin
                    if (pktReq) begin
                        addrReg <= next_addr;
                        setReg  <= next_set;
                        longReg <= wideAddr;
                        addrLen <= wideAddr ? ADDR_BYTES64 : ADDR_BYTES32;
                        ctxReg  <= next_ctx;
                        gtagReg <= guestTag;
                        ptagReg <= processTag;
                        addrCnt <= '0;
                        ptagCnt <= '0;
                        state   <= S_HDR;
                    end
                end
                S_HDR: begin
                    state <= S_ADDR;
                end
                S_ADDR: begin
                    addrCnt <= addrCnt + 4'h1;
                    if (addrCnt == addrLen - 4'h1) begin
                        state <= S_CTX;
                    end
                end
                S_CTX: begin
                    if (ctxReg[CTX_GTAG_BIT]) begin
                        state <= S_GTAG;
                    end else if (ctxReg[CTX_PTAG_BIT]) begin
                        state <= S_PTAG;
                    end else begin
                        state <= S_IDLE;
                    end
                end
                S_GTAG: begin
                    state <= ctxReg[CTX_PTAG_BIT] ? S_PTAG : S_IDLE;
                end
                S_PTAG: begin
                    ptagCnt <= ptagCnt + 4'h1;
                    if (ptagCnt == PTAG_BYTES - 4'h1) begin
                        state <= S_IDLE;
                    end
                end
                // Unused state codes fall back to idle
                default: state <= S_IDLE;
            endcase
        end
    end

    // Registered byte stream
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            byteValid <= 1'b0;
            byteData  <= '0;
            byteLast  <= 1'b0;
        end else begin
            byteValid <= (state != S_IDLE);
            byteLast  <= 1'b0;
            byteData  <= '0;
            unique case (state)
                S_IDLE: byteData <= '0;
                S_HDR: begin
                    if (longReg) begin
                        byteData <= (setReg == SET_COMPACT) ? HDR_COMPACT64 : HDR_WIDE64;
                    end else begin
                        byteData <= (setReg == SET_COMPACT) ? HDR_COMPACT32 : HDR_WIDE32;
                    end
                end
                S_ADDR: begin
                    if (addrCnt == 4'h0) begin
                        byteData <= addrByte0;
                    end else if (addrCnt == 4'h1) begin
                        byteData <= addrByte1;
                    end else begin
                        byteData <= addrReg[{addrCnt[2:0], 3'h0} +: 8];
                    end
                end
                S_CTX: begin
                    byteData <= ctxReg;
                    byteLast <= !ctxReg[CTX_GTAG_BIT] && !ctxReg[CTX_PTAG_BIT];
                end
                S_GTAG: begin
                    byteData <= gtagReg;
                    byteLast <= !ctxReg[CTX_PTAG_BIT];
                end
                S_PTAG: begin
                    byteData <= ptagReg[{ptagCnt[1:0], 3'h0} +: 8];
                    byteLast <= (ptagCnt == PTAG_BYTES - 4'h1);
                end
                default: byteData <= '0;
            endcase
        end
    end

    // History push once the address is formed
    assign hist.push = (state == S_IDLE) && pktReq;
    assign hist.newEntry.addr = next_addr;
    assign hist.newEntry.isa = next_set;

    // Acknowledge and newest-entry view
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            pktAck     <= 1'b0;
            newestAddr <= '0;
            newestSet  <= SET_WIDE;
        end else begin
            pktAck     <= (state == S_IDLE) && pktReq;
            newestAddr <= hist.entries[0].addr;
            newestSet  <= hist.entries[0].isa;
        end
    end

    // Checks
    sequence s_start;
        state == S_IDLE && pktReq;
    endsequence
    sequence s_hdr_out;
        byteValid && (byteData[7:4] == HDR_WIDE32[7:4]);
    endsequence
    property p_hdr_after_req;
        @(posedge core_clk) disable iff (rst) s_start |-> ##2 s_hdr_out;
    endproperty
    a_hdr_after_req: assert property (p_hdr_after_req) else $error("header not sent");
    property p_short_keeps_upper;
        @(posedge core_clk) disable iff (rst) (s_start and !wideAddr) |=>
            hist.entries[0].addr[63:32] == $past(hist.entries[0].addr[63:32]);
    endproperty
    a_short_keeps_upper: assert property (p_short_keeps_upper) else $error("upper bits lost");
    property p_long_full;
        @(posedge core_clk) disable iff (rst) (s_start and wideAddr) |=>
            hist.entries[0].addr[63:2] == $past(nextAddr[63:2]);
    endproperty
    a_long_full: assert property (p_long_full) else $error("full address not stored");
    property p_wide_align;
        @(posedge core_clk) disable iff (rst) hist.entries[0].isa == SET_WIDE |-> hist.entries[0].addr[1:0] == 2'h0;
    endproperty
    a_wide_align: assert property (p_wide_align) else $error("wide address misaligned");
    property p_compact_align;
        @(posedge core_clk) disable iff (rst) hist.entries[0].isa == SET_COMPACT |-> !hist.entries[0].addr[0];
    endproperty
    a_compact_align: assert property (p_compact_align) else $error("compact address odd");
    property p_shift;
        @(posedge core_clk) disable iff (rst) hist.push |=>
            hist.entries[2] == $past(hist.entries[1]) && hist.entries[1] == $past(hist.entries[0]);
    endproperty
    a_shift: assert property (p_shift) else $error("history not shifted");
    property p_ctx_fields;
        @(posedge core_clk) disable iff (rst) state == S_CTX |=>
            byteData[CTX_TIER_LSB +: 2] == $past(ctxReg[1:0]) && byteData[CTX_NS_BIT] == $past(ctxReg[CTX_NS_BIT]);
    endproperty
    a_ctx_fields: assert property (p_ctx_fields) else $error("context byte wrong");
    property p_no_gtag;
        @(posedge core_clk) disable iff (rst) state == S_CTX && !ctxReg[CTX_GTAG_BIT] |=> state != S_GTAG;
    endproperty
    a_no_gtag: assert property (p_no_gtag) else $error("guest tag not omitted");
    property p_ptag_len;
        @(posedge core_clk) disable iff (rst) $rose(state == S_PTAG) |-> (state == S_PTAG) [*4] ##1 state == S_IDLE;
    endproperty
    a_ptag_len: assert property (p_ptag_len) else $error("process tag length wrong");

    // Header checks timed from the taking edge, address byte checks timed from the address state and byte count
    sequence s_short_take;
        state == S_IDLE && pktReq && !wideAddr;
    endsequence
    sequence s_long_take;
        state == S_IDLE && pktReq && wideAddr;
    endsequence
    property p_ack_with_push;
        @(posedge core_clk) disable iff (rst) hist.push |=> pktAck;
    endproperty
    a_ack_with_push: assert property (p_ack_with_push) else $error("no acknowledge");
    property p_hdr_short;
        @(posedge core_clk) disable iff (rst) s_short_take |->
            ##2 (byteData == HDR_WIDE32 || byteData == HDR_COMPACT32);
    endproperty
    a_hdr_short: assert property (p_hdr_short) else $error("short header wrong");
    property p_hdr_long;
        @(posedge core_clk) disable iff (rst) s_long_take |->
            ##2 (byteData == HDR_WIDE64 || byteData == HDR_COMPACT64);
    endproperty
    a_hdr_long: assert property (p_hdr_long) else $error("long header wrong");
    property p_addr_top_gap;
        @(posedge core_clk) disable iff (rst) state == S_ADDR && addrCnt == 4'h0 |=> !byteData[7];
    endproperty
    a_addr_top_gap: assert property (p_addr_top_gap) else $error("first address byte top bit set");
    property p_wide_byte1_gap;
        @(posedge core_clk) disable iff (rst) state == S_ADDR && addrCnt == 4'h1 && setReg == SET_WIDE
            |=> !byteData[7];
    endproperty
    a_wide_byte1_gap: assert property (p_wide_byte1_gap) else $error("second wide byte top bit set");

    // Context and tag byte checks against the inputs at the taking edge, then last-flag checks from the framer state
    property p_ctx_short;
        @(posedge core_clk) disable iff (rst) s_short_take |-> ##7 byteValid
            && byteData[CTX_SF_BIT] == $past(widthStateFlag, 7) && byteData[CTX_NS_BIT] == $past(secureWorldFlag, 7);
    endproperty
    a_ctx_short: assert property (p_ctx_short) else $error("short context flags wrong");
    property p_ctx_long;
        @(posedge core_clk) disable iff (rst) s_long_take |-> ##11 byteValid
            && byteData[CTX_SF_BIT] == $past(widthStateFlag, 11) && byteData[CTX_NS_BIT] == $past(secureWorldFlag, 11);
    endproperty
    a_ctx_long: assert property (p_ctx_long) else $error("long context flags wrong");
    property p_gtag_short;
        @(posedge core_clk) disable iff (rst) (s_short_take and guestTagEn) |-> ##8 byteData == $past(guestTag, 8);
    endproperty
    a_gtag_short: assert property (p_gtag_short) else $error("guest tag byte wrong");
    property p_gtag_long;
        @(posedge core_clk) disable iff (rst) (s_long_take and guestTagEn) |-> ##12 byteData == $past(guestTag, 12);
    endproperty
    a_gtag_long: assert property (p_gtag_long) else $error("long guest tag byte wrong");
    property p_ptag_first;
        @(posedge core_clk) disable iff (rst) (s_short_take and !guestTagEn and processTagEn) |->
            ##8 byteData == $past(processTag[7:0], 8);
    endproperty
    a_ptag_first: assert property (p_ptag_first) else $error("process tag low byte wrong");
    property p_ptag_last_flag;
        @(posedge core_clk) disable iff (rst) state == S_PTAG && ptagCnt == PTAG_BYTES - 4'h1 |=> byteLast;
    endproperty
    a_ptag_last_flag: assert property (p_ptag_last_flag) else $error("last flag missing");
    property p_last_ends;
        @(posedge core_clk) disable iff (rst) byteLast |=> !byteValid;
    endproperty
    a_last_ends: assert property (p_last_ends) else $error("bytes after last");
endmodule

/* tacp_decoder.sv */
// Far-side packet decoder model producing context elements
module tacp_decoder (
    input  wire logic        core_clk,
    input  wire logic        rst,
    input  wire logic        byteValid,
    input  wire logic [7:0]  byteData,
    input  wire logic        byteLast,
    output logic             elemValid,
    output logic [43:0]      elemCtx
);
    timeunit 1ns;
    timeprecision 1ps;
    int         idx;
    int         nAddr;
    int         pos;
    logic [7:0] ctx;

    // Walks header, address, context and tag bytes of each packet
    always @(posedge core_clk or posedge rst) begin
        if (rst) begin
            idx = 0;
            nAddr = 4;
            ctx = 8'h00;
            elemValid <= 1'b0;
            elemCtx <= 44'h0;
        end else begin
            elemValid <= 1'b0;
            if (byteValid === 1'b1) begin
                if (idx == 0) begin
                    nAddr = (byteData == 8'h85 || byteData == 8'h86) ? 8 : 4;
                end else if (idx == nAddr + 1) begin
                    ctx = byteData;
                    elemCtx[43:40] <= {byteData[1:0], byteData[5], byteData[4]};
                end else if (idx > nAddr + 1) begin
                    pos = idx - nAddr - 2 - (ctx[6] ? 1 : 0);
                    if (ctx[6] && pos < 0) begin
                        elemCtx[39:32] <= byteData;
                    end else if (pos >= 0 && pos < 4) begin
                        elemCtx[8*pos +: 8] <= byteData;
                    end
                end
                // Absent tags keep the previous element's values
                elemValid <= byteLast;
                idx = (byteLast === 1'b1) ? 0 : idx + 1;
            end
        end
    end
endmodule

/* testbench.sv */
// Self-checking bench for the address-with-context framer
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    import tacp_pkg::*;
    logic        core_clk = 1'b0;
    logic        rst = 1'b1;
    logic        pktReq = 1'b0, wideAddr = 1'b0, compactSet = 1'b0, widthStateFlag = 1'b0;
    logic        secureWorldFlag = 1'b0, guestTagEn = 1'b0, processTagEn = 1'b0;
    logic [63:0] nextAddr = 64'h0;
    logic [1:0]  privilegeTier = 2'h0;
    logic [7:0]  guestTag = 8'h00;
    logic [31:0] processTag = 32'h0;
    logic        pktAck, byteValid, byteLast, elemValid;
    logic [7:0]  byteData;
    logic [63:0] newestAddr;
    logic [1:0]  newestSet;
    logic [43:0] elemCtx;
    logic [8:0]  expB [$];
    logic [43:0] expE [$];
    logic [63:0] hist0 = 64'h0;
    logic [7:0]  lastG = 8'h00;
    logic [31:0] lastP = 32'h0, seed = 32'h4, r;
    int          fails = 0, nTests = 0;

    always #2 core_clk = ~core_clk;

    tacp_framer u_tacp_framer (.core_clk(core_clk), .rst(rst), .pktReq(pktReq), .pktAck(pktAck),
        .wideAddr(wideAddr), .compactSet(compactSet), .nextAddr(nextAddr), .privilegeTier(privilegeTier),
        .widthStateFlag(widthStateFlag), .secureWorldFlag(secureWorldFlag), .guestTagEn(guestTagEn),
        .guestTag(guestTag), .processTagEn(processTagEn), .processTag(processTag), .byteValid(byteValid),
        .byteData(byteData), .byteLast(byteLast), .newestAddr(newestAddr), .newestSet(newestSet));
    tacp_decoder u_tacp_decoder (.core_clk(core_clk), .rst(rst), .byteValid(byteValid), .byteData(byteData),
        .byteLast(byteLast), .elemValid(elemValid), .elemCtx(elemCtx));

    // Shift register random source
    function automatic logic [31:0] rnd();
        seed = seed[0] ? ((seed >> 1) ^ 32'h80200003) : (seed >> 1);
        return seed;
    endfunction

    task check(input logic [63:0] seen, input logic [63:0] exp);
        nTests++;
        if (seen !== exp) begin
            fails++;
            $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
        end
    endtask

    task wrap_up;
        $display("comparisons %0d, mismatches %0d", nTests, fails);
        if (fails == 0 && nTests > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask

    // Requests one packet and notes its bytes and element
    task automatic send(input logic wide, input logic cset, input logic [63:0] a, input logic [1:0] tier,
                        input logic sf, input logic ns, input logic ge, input logic [7:0] g,
                        input logic pe, input logic [31:0] p);
        logic [63:0] f;
        logic [7:0]  ctx;
        int          n;
        int          w;
        n = wide ? 8 : 4;
        f = cset ? {a[63:1], 1'b0} : {a[63:2], 2'h0};
        if (!wide) f[63:32] = hist0[63:32];
        ctx = {pe, ge, ns, sf, 2'h0, tier};
        expB.push_back({1'b0, cset ? (wide ? HDR_COMPACT64 : HDR_COMPACT32) : (wide ? HDR_WIDE64 : HDR_WIDE32)});
        expB.push_back({2'h0, cset ? f[7:1] : f[8:2]});
        expB.push_back({1'b0, cset ? f[15:8] : {1'b0, f[15:9]}});
        for (int k = 2; k < n; k++) expB.push_back({1'b0, f[8*k +: 8]});
        expB.push_back({!(ge || pe), ctx});
        if (ge) expB.push_back({!pe, g});
        for (int k = 0; k < 4 && pe; k++) expB.push_back({k == 3, p[8*k +: 8]});
        if (ge) lastG = g;
        if (pe) lastP = p;
        expE.push_back({tier, ns, sf, lastG, lastP});
        @(negedge core_clk);
        {wideAddr, compactSet, nextAddr, privilegeTier, widthStateFlag} = {wide, cset, a, tier, sf};
        {secureWorldFlag, guestTagEn, guestTag, processTagEn, processTag} = {ns, ge, g, pe, p};
        pktReq = 1'b1;
        w = 0;
        while (pktAck !== 1'b1 && w < 60) begin
            @(negedge core_clk);
            w++;
        end
        pktReq = 1'b0;
        check(w < 60, 1'b1);
        // Newest view trails the history by one cycle
        @(negedge core_clk);
        check(newestAddr, f);
        check(newestSet, {1'b0, cset});
        hist0 = f;
    endtask

    // Result watcher takes the oldest note for each output
    always @(negedge core_clk) begin
        if (byteValid === 1'b1) check({byteLast, byteData}, expB.size() > 0 ? expB.pop_front() : 'x);
        if (elemValid === 1'b1) check(elemCtx, expE.size() > 0 ? expE.pop_front() : 'x);
    end

    // Variants in order, every tier, tag mixes, back to back
    initial begin
        repeat (10) @(posedge core_clk);
        @(negedge core_clk) rst = 1'b0;
        for (int i = 0; i < 40; i++) begin
            r = rnd();
            send(i[3], i[2], {rnd(), rnd()}, i[1:0], r[0], r[1], r[2] ^ i[0], r[15:8], i[4] ^ r[3], rnd());
        end
        repeat (30) @(negedge core_clk);
        check(expB.size(), 0);
        check(expE.size(), 0);
        wrap_up;
    end

    // Hang guard
    initial begin
        #20000;
        fails++;
        wrap_up;
    end
endmodule
